/* File: common/ocf_pkg.sv */
package ocf_pkg;

    // ----------------------------------------------------------------
    // Command codes
    // ----------------------------------------------------------------
    localparam logic [7:0]  CMD_THRESHOLD      = 8'h46;   // Phased threshold word
    localparam logic [7:0]  CMD_ACTION         = 8'h47;   // Non-phased response byte
    localparam logic [7:0]  PHASE_BROADCAST    = 8'hFF;   // Phase selector: all phases
    localparam logic [7:0]  PHASE_CONTROLLER   = 8'h00;   // Loop controller phase

    // ----------------------------------------------------------------
    // Threshold word layout and limits (quarter-amp units)
    // ----------------------------------------------------------------
    localparam int          EXP_MSB            = 15;      // Exponent field top bit
    localparam int          EXP_LSB            = 11;      // Exponent field low bit
    localparam int          MAN_MSB            = 10;      // Mantissa field top bit
    localparam logic [4:0]  EXP_RESET          = 5'h1E;   // Fixed exponent, 0.25 A per count
    localparam logic [10:0] MAN_RESET          = 11'h0A0; // 40 A until storage is read
    localparam logic [10:0] MAN_MAX_PHASE      = 11'h0F8; // 62 A per phase
    localparam logic [5:0]  HW_MIN_AMPS        = 6'h08;   // Smallest analog level
    localparam logic [5:0]  HW_STEP_AMPS       = 6'h02;   // Analog level spacing
    localparam int          QUARTERS_PER_STEP  = 8;       // 2 A in quarter amps
    localparam int          NVM_FRAC_SHIFT     = 2;       // Storage is 1/16 A, keep 1/4 A

    // ----------------------------------------------------------------
    // Response byte layout
    // ----------------------------------------------------------------
    localparam int          ACT_MSB            = 7;       // Action select top bit
    localparam int          RETRY_MSB          = 5;       // Retry field top bit
    localparam int          RETRY_LSB          = 3;       // Retry field low bit
    localparam int          DELAY_MSB          = 2;       // Delay field top bit
    localparam logic [7:0]  ACTION_RESET       = 8'hC0;   // Immediate latch-off
    localparam logic [2:0]  RETRY_FOREVER      = 3'h7;    // Endless restart_wait_period
    localparam logic [2:0]  DELAY_SHORT        = 3'h1;    // One switching clock
    localparam logic [2:0]  DELAY_MID          = 3'h3;    // Three switching clocks
    localparam logic [2:0]  DELAY_LONG         = 3'h7;    // Seven switching clocks

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int          RISE_TIME_TICKS    = 100;     // Rise time in switching clocks

    // ----------------------------------------------------------------
    // Carriers and states
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        valid;   // One-cycle request strobe
        logic        write;   // 1 write, 0 read
        logic [7:0]  code;    // Command code
        logic [15:0] wdata;   // Write data, byte commands use low byte
    } cmd_s;

    typedef struct packed {
        logic        status_byte_oc;   // Overcurrent bit of summary byte
        logic        status_word_iout; // Output-current bit of summary word
        logic        current_fault_flag; // Overcurrent fault bit of current status
        logic        invalid_data;     // Bad data received
    } status_s;

    typedef enum logic [2:0] {
        ST_RUN     = 3'b000,
        ST_DELAY   = 3'b001,
        ST_RESTART_WAIT_PERIOD  = 3'b011,
        ST_RESTART = 3'b010,
        ST_LATCHED = 3'b110
    } fault_state_e;

endpackage : ocf_pkg

/* File: core/overcurrent_fault_limit_response.sv */
`timescale 1ns/100ps
module overcurrent_fault_limit_response #(
    parameter int N_PHASES   = 4,                        // Phases this bank can hold
    parameter int RISE_TICKS = ocf_pkg::RISE_TIME_TICKS  // Rise time in switching clocks
) (
    input  wire logic                          i_clk,
    input  wire logic                          i_sys_rst,
    input  wire ocf_pkg::cmd_s                 i_cmd,
    input  wire logic [7:0]                    i_phase_sel,
    input  wire logic [2:0]                    i_phase_count,
    input  wire logic                          i_nvm_restore,
    input  wire logic [9:0]                    i_nvm_threshold,
    input  wire logic [7:0]                    i_nvm_action,
    input  wire logic                          i_pwm_clk,
    input  wire logic                          i_oc_trip,
    input  wire logic                          i_startup_done,
    input  wire logic                          i_cmd_off,
    input  wire logic                          i_clear_faults,
    output logic [15:0]                        o_rdata,
    output logic                               o_rvalid,
    output logic                               o_cmd_error,
    output logic [N_PHASES-1:0][5:0]           o_hw_amps,
    output logic [8:0]                         o_stack_limit,
    output logic                               o_power_enable,
    output ocf_pkg::status_s                   o_status,
    output logic                               o_alert
);
    import ocf_pkg::*;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [N_PHASES-1:0][10:0] mantissa;        // Per-phase threshold, quarter amps
    logic [7:0]                action;          // Response byte
    logic                      restore_pend;    // Storage load due after reset
    logic [2:0]                pwm_sync;        // Two stages plus edge history
    logic [1:0]                trip_sync;       // Comparator synchroniser
    logic                      trip_prev;       // For rising-edge detect
    logic                      pwm_tick;        // One cycle per switching clock
    logic                      trip_rise;       // New overcurrent event
    logic [2:0]                phases;          // Active phase count, never zero
    logic                      wr_thr;          // Valid threshold write accepted
    logic                      wr_bad;          // Refused write or read
    logic [10:0]               wr_man;          // Mantissa after broadcast split
    fault_state_e              state;           // Fault response state
    logic [15:0]               tick_cnt;        // Delay or restart_wait_period countdown
    logic [2:0]                attempts;        // Restart attempts so far

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Divide by 1..4; the third uses a reciprocal exact below 2048
    function automatic logic [10:0] split(input logic [10:0] v, input logic [2:0] n);
        logic [21:0] prod;
        prod = 22'(v) * 22'd683;
        case (n)
            3'd2:    split = v >> 1;
            3'd3:    split = prod[21:11];
            3'd4:    split = v >> 2;
            default: split = v;
        endcase
    endfunction : split

    // Quarter amps to analog level in amps, rounded up, floored at minimum
    function automatic logic [5:0] hw_level(input logic [10:0] m);
        logic [7:0] steps;
        logic [5:0] amps;
        steps = 8'((m + 11'(QUARTERS_PER_STEP - 1)) / 11'(QUARTERS_PER_STEP));
        amps  = 6'(steps) * HW_STEP_AMPS;
        hw_level = (amps < HW_MIN_AMPS) ? HW_MIN_AMPS : amps;
    endfunction : hw_level

    // Shutdown delay in switching clocks
    function automatic logic [2:0] delay_clocks(input logic [2:0] code);
        if (code <= 3'd1) begin
            delay_clocks = DELAY_SHORT;
        end else if (code <= 3'd4) begin
            delay_clocks = DELAY_MID;
        end else begin
            delay_clocks = DELAY_LONG;
        end
    endfunction : delay_clocks

    // Restart_wait_period length in rise times
    function automatic logic [2:0] restart_wait_period_mult(input logic [2:0] code);
        restart_wait_period_mult = (code <= 3'd1) ? 3'd1 : code;
    endfunction : restart_wait_period_mult

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    // Switching clock and comparator are both foreign to i_clk
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            pwm_sync  <= 3'h0;
            trip_sync <= 2'h0;
            trip_prev <= 1'b0;
        end else begin
            pwm_sync  <= {pwm_sync[1:0], i_pwm_clk};
            trip_sync <= {trip_sync[0], i_oc_trip};
            trip_prev <= trip_sync[1];
        end
    end

    // Only second-stage taps feed logic
    assign pwm_tick  = pwm_sync[1] & ~pwm_sync[2];
    assign trip_rise = trip_sync[1] & ~trip_prev;
    assign phases    = (i_phase_count == 3'd0) ? 3'd1 : i_phase_count;

    // ----------------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------------
    // Validity of threshold writes; response byte has no illegal code
    always_comb begin
        wr_thr = 1'b0;
        wr_bad = 1'b0;
        wr_man = split(i_cmd.wdata[MAN_MSB:0], phases);
        if (!i_cmd.valid) begin
            wr_bad = 1'b0;
        end else if (i_cmd.code == CMD_THRESHOLD) begin
            if (!i_cmd.write) begin
                // Read of a phase beyond the stack is refused
                wr_bad = (i_phase_sel != PHASE_BROADCAST) && (i_phase_sel >= 8'(phases));
            end else if (i_cmd.wdata[EXP_MSB:EXP_LSB] != EXP_RESET) begin
                wr_bad = 1'b1;
            end else if (i_cmd.wdata[MAN_MSB]) begin
                wr_bad = 1'b1;
            end else if (i_phase_sel == PHASE_BROADCAST) begin
                // Stack total may reach 62 A times phases
                wr_bad = (wr_man > MAN_MAX_PHASE);
                wr_thr = !wr_bad;
            end else begin
                wr_man = i_cmd.wdata[MAN_MSB:0];
                wr_bad = (wr_man > MAN_MAX_PHASE) || (i_phase_sel >= 8'(phases));
                wr_thr = !wr_bad;
            end
        end else if (i_cmd.code == CMD_ACTION) begin
            wr_bad = 1'b0;
        end else begin
            // Unsupported command code
            wr_bad = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Threshold storage, one per phase
    // ----------------------------------------------------------------
    // Storage restore wins over a same-cycle host write
    generate
        for (genvar p = 0; p < N_PHASES; p++) begin : g_phase
            always_ff @(posedge i_clk) begin
                if (i_sys_rst) begin
                    mantissa[p] <= MAN_RESET;
                end else if (restore_pend || i_nvm_restore) begin
                    // Round 1/16 A storage to nearest quarter amp
                    mantissa[p] <= 11'((i_nvm_threshold + 10'd2) >> NVM_FRAC_SHIFT);
                end else if (wr_thr && (i_phase_sel == PHASE_BROADCAST)) begin
                    mantissa[p] <= wr_man;
                end else if (wr_thr && (i_phase_sel == 8'(p))) begin
                    mantissa[p] <= wr_man;
                end
            end

            // Analog level, registered so the output comes from a flop
            always_ff @(posedge i_clk) begin
                if (i_sys_rst) begin
                    o_hw_amps[p] <= HW_MIN_AMPS;
                end else begin
                    o_hw_amps[p] <= hw_level(mantissa[p]);
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Stack limit
    // ----------------------------------------------------------------
    // Weakest active phase sets the limit of the whole stack
    always_ff @(posedge i_clk) begin
        logic [5:0] low;
        low = 6'h3F;
        for (int p = 0; p < N_PHASES; p++) begin
            if ((3'(p) < phases) && (o_hw_amps[p] < low)) begin
                low = o_hw_amps[p];
            end
        end
        if (i_sys_rst) begin
            o_stack_limit <= 9'h000;
        end else begin
            o_stack_limit <= 9'(low) * 9'(phases);
        end
    end

    // ----------------------------------------------------------------
    // Response byte and storage load
    // ----------------------------------------------------------------
    // One byte shared by all phases, may change while running
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            action       <= ACTION_RESET;
            restore_pend <= 1'b1;
        end else begin
            restore_pend <= 1'b0;
            if (restore_pend || i_nvm_restore) begin
                action <= i_nvm_action;
            end else if (i_cmd.valid && i_cmd.write && (i_cmd.code == CMD_ACTION)) begin
                action <= i_cmd.wdata[7:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Answer one cycle after the read strobe
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_rdata     <= 16'h0000;
            o_rvalid    <= 1'b0;
            o_cmd_error <= 1'b0;
        end else begin
            o_rvalid    <= i_cmd.valid && !i_cmd.write;
            o_cmd_error <= wr_bad;
            if (!i_cmd.valid || i_cmd.write || wr_bad) begin
                o_rdata <= 16'h0000;
            end else if (i_cmd.code == CMD_ACTION) begin
                o_rdata <= {8'h00, action};
            end else if (i_phase_sel == PHASE_BROADCAST) begin
                // Controller value scaled up to the stack total
                o_rdata <= {EXP_RESET, 11'(mantissa[0] * 11'(phases))};
            end else begin
                o_rdata <= {EXP_RESET, mantissa[i_phase_sel[1:0]]};
            end
        end
    end

    // ----------------------------------------------------------------
    // Status flags
    // ----------------------------------------------------------------
    // Sticky; a new event in the clear cycle still lands
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_status <= '0;
            o_alert  <= 1'b0;
        end else begin
            if (trip_rise) begin
                o_status.status_byte_oc     <= 1'b1;
                o_status.status_word_iout   <= 1'b1;
                o_status.current_fault_flag <= 1'b1;
            end else if (i_clear_faults) begin
                o_status.status_byte_oc     <= 1'b0;
                o_status.status_word_iout   <= 1'b0;
                o_status.current_fault_flag <= 1'b0;
            end
            if (wr_bad) begin
                o_status.invalid_data <= 1'b1;
            end else if (i_clear_faults) begin
                o_status.invalid_data <= 1'b0;
            end
            // Alert line held while any event is pending
            o_alert <= trip_rise || wr_bad ||
                       (!i_clear_faults && (o_status != '0));
        end
    end

    // ----------------------------------------------------------------
    // Fault response state machine
    // ----------------------------------------------------------------
    // Counts run in switching clocks so delays track the converter
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state    <= ST_RUN;
            tick_cnt <= 16'h0000;
            attempts <= 3'h0;
        end else if (i_cmd_off) begin
            // Commanded off releases any latch and forgets retries
            state    <= ST_RUN;
            tick_cnt <= 16'h0000;
            attempts <= 3'h0;
        end else begin
            case (state)
                ST_RUN: begin
                    if (trip_rise && action[ACT_MSB]) begin
                        if (action[ACT_MSB-1]) begin
                            tick_cnt <= 16'h0000;
                            state    <= ST_DELAY;                            // Immediate: zero wait
                        end else begin
                            tick_cnt <= 16'(delay_clocks(action[DELAY_MSB:0]));
                            state    <= ST_DELAY;
                        end
                    end
                end
                ST_DELAY: begin
                    if (tick_cnt != 16'h0000) begin
                        if (pwm_tick) begin
                            tick_cnt <= tick_cnt - 16'h0001;
                        end
                    end else if (action[RETRY_MSB:RETRY_LSB] == 3'h0) begin
                        state <= ST_LATCHED;
                    end else if ((action[RETRY_MSB:RETRY_LSB] == RETRY_FOREVER) ||
                                 (attempts < action[RETRY_MSB:RETRY_LSB])) begin
                        tick_cnt <= 16'(restart_wait_period_mult(action[DELAY_MSB:0]) * RISE_TICKS);
                        state    <= ST_RESTART_WAIT_PERIOD;
                    end else begin
                        state <= ST_LATCHED;
                    end
                end
                ST_RESTART_WAIT_PERIOD: begin
                    if (tick_cnt != 16'h0000) begin
                        if (pwm_tick) begin
                            tick_cnt <= tick_cnt - 16'h0001;
                        end
                    end else begin
                        // Endless mode keeps the count from wrapping
                        if (attempts != RETRY_FOREVER) begin
                            attempts <= attempts + 3'h1;
                        end
                        state <= ST_RESTART;
                    end
                end
                ST_RESTART: begin
                    if (trip_rise) begin
                        tick_cnt <= 16'h0000;
                        state    <= ST_DELAY;
                    end else if (i_startup_done) begin
                        attempts <= 3'h0;
                        state    <= ST_RUN;
                    end
                end
                ST_LATCHED: begin
                    // Left only by a command off
                    state <= ST_LATCHED;
                end
                default: begin
                    state <= ST_RUN;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Power stage enable
    // ----------------------------------------------------------------
    // Delayed shutdown keeps switching until the delay runs out
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_power_enable <= 1'b0;
        end else if (i_cmd_off) begin
            o_power_enable <= 1'b0;
        end else begin
            o_power_enable <= (state == ST_RUN) || (state == ST_RESTART) ||
                              ((state == ST_DELAY) && (tick_cnt != 16'h0000));
        end
    end

endmodule : overcurrent_fault_limit_response

/* File: tb/ocf_plant.sv */
`timescale 1ns/100ps
// Power stage side: free switching clock, start-up done after a lag
module ocf_plant (
    input  wire logic       i_clk,
    input  wire logic       i_pwr,
    input  wire logic [3:0] i_lag,
    output logic            o_pwm,
    output logic            o_done
);
    logic [3:0] cnt; // Cycles since power came up
    // Offset start keeps its edges clear of the system clock edges
    initial begin
        o_pwm = 1'b0;
        #13;
        forever #200 o_pwm = ~o_pwm;
    end
    always_ff @(posedge i_clk) begin
        cnt    <= i_pwr ? cnt + 4'h1 : 4'h0;
        o_done <= i_pwr && cnt == i_lag;
    end
endmodule : ocf_plant

/* File: tb/ocf_properties.sv */
`timescale 1ns/100ps
module ocf_properties #(parameter int N_PHASES = 4) (
    input wire logic i_clk, i_sys_rst, i_nvm_restore, i_pwm_clk, i_oc_trip, i_startup_done,
    input wire logic i_cmd_off, i_clear_faults, o_rvalid, o_cmd_error, o_power_enable, o_alert,
    input wire ocf_pkg::cmd_s i_cmd,
    input wire logic [7:0] i_phase_sel, i_nvm_action,
    input wire logic [2:0] i_phase_count,
    input wire logic [9:0] i_nvm_threshold,
    input wire logic [15:0] o_rdata,
    input wire logic [8:0] o_stack_limit,
    input wire logic [N_PHASES-1:0][5:0] o_hw_amps,
    input wire ocf_pkg::status_s o_status
);
    import ocf_pkg::*;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    logic [7:0] act; // Response byte the bank should hold
    // Shadow of the response byte, so fault checks know the policy
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || i_nvm_restore) act <= i_nvm_action;
        else if (i_cmd.valid && i_cmd.write && i_cmd.code == CMD_ACTION) act <= i_cmd.wdata[7:0];
    end
    // Fresh trip while power is enabled; trips with power off are ignored
    sequence trip_s; $rose(i_oc_trip) && o_power_enable && !i_cmd_off; endsequence
    chk_read_answer: assert property (i_cmd.valid && !i_cmd.write |=> o_rvalid)
        else $error("read not answered");
    chk_bad_code: assert property (i_cmd.valid && i_cmd.code[7:1] != 7'h23 |=> o_cmd_error)
        else $error("unknown code not refused");
    chk_byte_taken: assert property (i_cmd.valid && i_cmd.write && i_cmd.code == CMD_ACTION |=> !o_cmd_error)
        else $error("response byte refused");
    chk_level_span: assert property (o_hw_amps[0] inside {[6'h08:6'h3E]} && !o_hw_amps[0][0])
        else $error("analog level off grid");
    chk_alert_set: assert property (|o_status |-> o_alert)
        else $error("status set without alert");
    chk_fault_flags: assert property (trip_s |-> ##[2:6] o_status[3:1] == 3'h7)
        else $error("fault flags missing");
    chk_stop_now: assert property (trip_s ##0 act[7:6] == 2'h3 |-> ##[2:7] !o_power_enable)
        else $error("immediate shutdown late");
    chk_ignore_runs: assert property (trip_s ##0 !act[7] |-> ##1 o_power_enable [*8])
        else $error("ignored fault stopped power");
    chk_off_wins: assert property (i_cmd_off |=> !o_power_enable)
        else $error("power on while commanded off");
endmodule : ocf_properties
bind overcurrent_fault_limit_response ocf_properties #(.N_PHASES(N_PHASES)) u_chk (.*);

/* File: tb/overcurrent_fault_limit_response_test.sv */
`timescale 1ns/100ps
module overcurrent_fault_limit_response_test;
    import ocf_pkg::*;
    logic clk = 0, rst = 1, restore = 0, trip = 0, off = 0, clr = 0, pwm, done, rv, err, pwr, alert;
    cmd_s cmd = '0;
    logic [7:0] sel = 8'h00;
    logic [15:0] rd;
    logic [3:0][5:0] hw;
    logic [8:0] stk;
    status_s st;
    logic [7:0] acts[4] = '{8'h40, 8'hC0, 8'h80, 8'hCA};
    int mismatches = 0, n_tests = 0, m[4];
    always #25 clk = ~clk;
    ocf_plant u_plant (.i_clk(clk), .i_pwr(pwr), .i_lag(4'h3), .o_pwm(pwm), .o_done(done));
    overcurrent_fault_limit_response #(.RISE_TICKS(2)) u_dut (.i_clk(clk), .i_sys_rst(rst), .i_cmd(cmd),
        .i_phase_sel(sel), .i_phase_count(3'h4), .i_nvm_restore(restore), .i_nvm_threshold(10'h0A2),
        .i_nvm_action(8'h00), .i_pwm_clk(pwm), .i_oc_trip(trip), .i_startup_done(done),
        .i_cmd_off(off), .i_clear_faults(clr), .o_rdata(rd), .o_rvalid(rv), .o_cmd_error(err),
        .o_hw_amps(hw), .o_stack_limit(stk), .o_power_enable(pwr), .o_status(st), .o_alert(alert));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic close_out;
        $display("tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : close_out
    // One request strobe, then a bounded wait for its answer
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                        output logic [15:0] r, output logic e);
        int k;
        @(negedge clk);
        cmd = '{1'b1, w, c, d};
        @(negedge clk);
        cmd.valid = 1'b0;
        for (k = 0; k < 3 && !(rv || err); k++) @(negedge clk);
        r = rd;
        e = err;
    endtask : xfer
    initial begin
        #4000000;
        mismatches++;
        close_out();
    end
    initial begin
        logic [15:0] r;
        logic e;
        int p, v, lv, mn, k;
        void'($urandom(37700));
        repeat (10) @(negedge clk);
        rst = 0;
        repeat (3) @(negedge clk);
        xfer(0, CMD_THRESHOLD, 0, r, e); check(r, 16'hF029);
        mn = 62;
        for (p = 0; p < 4; p++) begin
            sel = p[7:0];
            m[p] = (p == 0) ? $urandom_range(31) : (p == 3) ? 248 : $urandom_range(248);
            xfer(1, CMD_THRESHOLD, {5'h1E, 11'(m[p])}, r, e); check(e, 0);
            xfer(0, CMD_THRESHOLD, 0, r, e); check(r, {5'h1E, 11'(m[p])});
            lv = (m[p] + 7) / 8 * 2;
            if (lv < 8) lv = 8;
            if (lv < mn) mn = lv;
            check(hw[p], lv);
        end
        check(stk, mn * 4);
        sel = PHASE_BROADCAST;
        v = $urandom_range(992);
        xfer(1, CMD_THRESHOLD, {5'h1E, 11'(v)}, r, e);
        xfer(0, CMD_THRESHOLD, 0, r, e); check(r, {5'h1E, 11'(v / 4 * 4)});
        sel = 8'h02;
        xfer(0, CMD_THRESHOLD, 0, r, e); check(r, {5'h1E, 11'(v / 4)});
        xfer(1, CMD_THRESHOLD, 16'h00F0, r, e); check(e, 1);
        xfer(1, CMD_THRESHOLD, 16'hF0F9, r, e); check(e, 1);
        xfer(0, 8'h48, 0, r, e); check(e, 1);
        xfer(0, CMD_THRESHOLD, 0, r, e); check(r, {5'h1E, 11'(v / 4)});
        check(st.invalid_data & alert, 1);
        // Each policy: trip, then see whether power comes back
        foreach (acts[i]) begin
            xfer(1, CMD_ACTION, acts[i], r, e);
            xfer(0, CMD_ACTION, 0, r, e); check(r, acts[i]);
            clr = 1; @(negedge clk); clr = 0;
            trip = 1; repeat (20) @(negedge clk); trip = 0;
            check(st.current_fault_flag & st.status_byte_oc & st.status_word_iout, 1);
            check(pwr, !acts[i][7]);
            for (k = 0; k < 120 && !(pwr && done); k++) @(negedge clk);
            check(pwr, !acts[i][7] || acts[i][5:3] != 0);
            off = 1; repeat (2) @(negedge clk); off = 0; repeat (6) @(negedge clk);
        end
        restore = 1; @(negedge clk); restore = 0;
        sel = 8'h00;
        xfer(0, CMD_THRESHOLD, 0, r, e); check(r, 16'hF029);
        close_out();
    end
endmodule : overcurrent_fault_limit_response_test
